// ---- rtl/spw_serial_port.v ----
`timescale 1ns/10ps
`include "spw_regs.vh"
// Summary of operation
// - Transmit serial characters on txd and receive them on rxd.
// - Pin directions are those of terminal equipment, not a modem.
// - With software flow selected, rts stays asserted always.
// - With hardware flow, rts asserted only while receive holding is free.
// - Start a character only while cts is asserted.
// - dtr is asserted whenever the block is out of reset.
// - Character width is seven or eight bits.
// - Serial remote control puts the instrument bus into talk-only.
// - Setting changes take effect immediately, no apply step.
// - Parity odd, even or none, generated and checked.
// - One or two stop bits selectable.
// - Bit rate set by a divisor register.
// - A setting chooses the remote-control port.
// - Instrument bus address is configurable.
module spw_serial_port (
    input  wire        core_clk,
    input  wire        reset,
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire        rxd,
    input  wire        cts,
    output reg         txd,
    output reg         rts,
    output reg         dtr,
    output reg         gpib_talk_only,
    output reg  [4:0]  gpib_address
);
    localparam ST_IDLE  = 5'b00001;
    localparam ST_START = 5'b00010;
    localparam ST_DATA  = 5'b00100;
    localparam ST_PAR   = 5'b01000;
    localparam ST_STOP  = 5'b10000;

    reg [7:0]  ctrl_reg;
    reg [15:0] baud_reg;
    reg [7:0]  tx_hold_reg;
    reg        tx_full_reg;
    reg [7:0]  rx_hold_reg;
    reg        rx_full_reg;
    reg        rx_par_err_reg;
    reg        rx_frm_err_reg;
    reg        rx_ovr_reg;
    reg        xoff_reg;
    reg        rxd_s1_reg;
    reg        rxd_s2_reg;
    reg        cts_s1_reg;
    reg        cts_s2_reg;

    // ==========================================================
    // Settings decoded straight from the control register.
    wire       eight    = ctrl_reg[`SPW_CTRL_EIGHT];
    wire       par_en   = ctrl_reg[`SPW_CTRL_PAR_EN];
    wire       par_odd  = ctrl_reg[`SPW_CTRL_PAR_ODD];
    wire       two_stop = ctrl_reg[`SPW_CTRL_TWO_STOP];
    wire       sw_flow  = ctrl_reg[`SPW_CTRL_SW_FLOW];
    wire [2:0] last_bit = eight ? 3'h7 : 3'h6;

    // ==========================================================
    // Synchronisers for the pins from the far party.
    always @(posedge core_clk) begin
        if (reset) begin
            rxd_s1_reg <= 1'b1;
            rxd_s2_reg <= 1'b1;
            cts_s1_reg <= 1'b0;
            cts_s2_reg <= 1'b0;
        end else begin
            rxd_s1_reg <= rxd;
            rxd_s2_reg <= rxd_s1_reg;
            cts_s1_reg <= cts;
            cts_s2_reg <= cts_s1_reg;
        end
    end

    // ==========================================================
    // Transmitter.
    reg [4:0] tx_state_reg;
    reg [2:0] tx_bit_reg;
    reg [7:0] tx_shift_reg;
    reg       tx_par_reg;
    reg       tx_stop2_reg;
    reg       tx_restart;
    wire      tx_tick;
    wire      tx_take = tx_state_reg == ST_IDLE && tx_full_reg && cts_s2_reg
                        && !(sw_flow && xoff_reg);

    spw_bit_timer #(.WIDTH(16)) u_tx_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .restart  (tx_take),
        .divisor  (baud_reg),
        .tick     (tx_tick)
    );

    always @(posedge core_clk) begin
        if (reset) begin
            tx_state_reg <= ST_IDLE;
            tx_bit_reg   <= 3'h0;
            tx_shift_reg <= 8'h00;
            tx_par_reg   <= 1'b0;
            tx_stop2_reg <= 1'b0;
            txd          <= 1'b1;
        end else begin
            case (tx_state_reg)
                ST_IDLE: begin
                    txd <= 1'b1;
                    if (tx_take) begin
                        tx_shift_reg <= tx_hold_reg;
                        tx_par_reg   <= par_odd;
                        tx_bit_reg   <= 3'h0;
                        tx_state_reg <= ST_START;
                        txd          <= 1'b0;
                    end
                end
                ST_START: begin
                    if (tx_tick) begin
                        txd          <= tx_shift_reg[0];
                        tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_state_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tx_tick) begin
                        if (tx_bit_reg == last_bit) begin
                            tx_stop2_reg <= two_stop;
                            if (par_en) begin
                                txd          <= tx_par_reg;
                                tx_state_reg <= ST_PAR;
                            end else begin
                                txd          <= 1'b1;
                                tx_state_reg <= ST_STOP;
                            end
                        end else begin
                            tx_bit_reg   <= tx_bit_reg + 3'h1;
                            txd          <= tx_shift_reg[0];
                            tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
                            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        end
                    end
                end
                ST_PAR: begin
                    if (tx_tick) begin
                        txd          <= 1'b1;
                        tx_state_reg <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tx_tick) begin
                        if (tx_stop2_reg) begin
                            tx_stop2_reg <= 1'b0;
                        end else begin
                            tx_state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state_reg <= ST_IDLE;
                    txd          <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Receiver. Its own bit counter starts on the start edge, so sampling
    // at half count lands in the middle of every bit.
    reg [4:0]  rx_state_reg;
    reg [2:0]  rx_bit_reg;
    reg [7:0]  rx_shift_reg;
    reg        rx_par_reg;
    reg [15:0] rx_cnt_reg;
    reg        rx_prev_reg;
    wire       rx_mid = rx_cnt_reg == {1'b0, baud_reg[15:1]};
    wire       rx_end = rx_cnt_reg >= baud_reg;
    wire       rx_done = rx_state_reg == ST_STOP && rx_mid;
    wire [7:0] rx_char = eight ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};

    always @(posedge core_clk) begin
        if (reset) begin
            rx_state_reg <= ST_IDLE;
            rx_bit_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_par_reg   <= 1'b0;
            rx_cnt_reg   <= 16'h0000;
            rx_prev_reg  <= 1'b1;
        end else begin
            rx_prev_reg <= rxd_s2_reg;
            rx_cnt_reg  <= (rx_end || rx_state_reg == ST_IDLE) ? 16'h0000
                           : rx_cnt_reg + 16'h0001;
            case (rx_state_reg)
                ST_IDLE: begin
                    if (rx_prev_reg && !rxd_s2_reg) begin
                        rx_state_reg <= ST_START;
                        rx_par_reg   <= par_odd;
                        rx_bit_reg   <= 3'h0;
                    end
                end
                ST_START: begin
                    if (rx_mid) begin
                        rx_state_reg <= rxd_s2_reg ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx_mid) begin
                        rx_shift_reg <= {rxd_s2_reg, rx_shift_reg[7:1]};
                        rx_par_reg   <= rx_par_reg ^ rxd_s2_reg;
                        rx_bit_reg   <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == last_bit) begin
                            rx_state_reg <= par_en ? ST_PAR : ST_STOP;
                        end
                    end
                end
                ST_PAR: begin
                    if (rx_mid) begin
                        rx_par_reg   <= rx_par_reg ^ rxd_s2_reg;
                        rx_state_reg <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (rx_mid) begin
                        rx_state_reg <= ST_IDLE;
                    end
                end
                default: rx_state_reg <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Register file and holding buffers. Status sets win over clears.
    // Under software flow, XON and XOFF are consumed by the port and never reach software.
    wire rx_is_flow = sw_flow && (rx_char == `SPW_XON || rx_char == `SPW_XOFF);
    wire rd_rx      = reg_rd && reg_addr == `SPW_ADDR_RXDATA;
    wire tx_wr      = reg_wr && reg_addr == `SPW_ADDR_TXDATA;

    always @(posedge core_clk) begin
        if (reset) begin
            ctrl_reg       <= `SPW_CTRL_RESET;
            baud_reg       <= `SPW_BAUD_RESET;
            gpib_address   <= `SPW_GPIB_RESET;
            tx_hold_reg    <= 8'h00;
            tx_full_reg    <= 1'b0;
            rx_hold_reg    <= 8'h00;
            rx_full_reg    <= 1'b0;
            rx_par_err_reg <= 1'b0;
            rx_frm_err_reg <= 1'b0;
            rx_ovr_reg     <= 1'b0;
            xoff_reg       <= 1'b0;
            reg_rdata      <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == `SPW_ADDR_CTRL) begin
                ctrl_reg <= reg_wdata[7:0];
            end
            if (reg_wr && reg_addr == `SPW_ADDR_BAUD) begin
                baud_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == `SPW_ADDR_GPIB) begin
                gpib_address <= reg_wdata[4:0];
            end
            // A write in the cycle the held character leaves must not be lost.
            if (tx_wr && (!tx_full_reg || tx_take)) begin
                tx_hold_reg <= eight ? reg_wdata[7:0] : {1'b0, reg_wdata[6:0]};
            end
            if (tx_wr) begin
                tx_full_reg <= 1'b1;
            end else if (tx_take) begin
                tx_full_reg <= 1'b0;
            end
            if (!sw_flow) begin
                xoff_reg <= 1'b0;
            end else if (rx_done && rx_char == `SPW_XOFF) begin
                xoff_reg <= 1'b1;
            end else if (rx_done && rx_char == `SPW_XON) begin
                xoff_reg <= 1'b0;
            end
            if (rx_done && !rx_is_flow) begin
                rx_full_reg    <= 1'b1;
                rx_hold_reg    <= rx_full_reg ? rx_hold_reg : rx_char;
                rx_ovr_reg     <= rx_ovr_reg | rx_full_reg;
                rx_par_err_reg <= (rx_par_err_reg & ~rd_rx) | (par_en & rx_par_reg);
                rx_frm_err_reg <= (rx_frm_err_reg & ~rd_rx) | ~rxd_s2_reg;
            end else if (rd_rx) begin
                rx_full_reg    <= 1'b0;
                rx_ovr_reg     <= 1'b0;
                rx_par_err_reg <= 1'b0;
                rx_frm_err_reg <= 1'b0;
            end
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    `SPW_ADDR_CTRL:   reg_rdata <= {8'h00, ctrl_reg};
                    `SPW_ADDR_BAUD:   reg_rdata <= baud_reg;
                    `SPW_ADDR_TXDATA: reg_rdata <= {8'h00, tx_hold_reg};
                    `SPW_ADDR_RXDATA: reg_rdata <= {8'h00, rx_hold_reg};
                    `SPW_ADDR_STATUS: reg_rdata <= {8'h00, cts_s2_reg, xoff_reg,
                                                    tx_state_reg != ST_IDLE,
                                                    rx_ovr_reg, rx_frm_err_reg,
                                                    rx_par_err_reg, rx_full_reg,
                                                    tx_full_reg};
                    `SPW_ADDR_GPIB:   reg_rdata <= {11'h000, gpib_address};
                    default:          reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // ==========================================================
    // Handshake outputs, registered so each pin comes from a flip-flop.
    always @(posedge core_clk) begin
        if (reset) begin
            rts            <= 1'b0;
            dtr            <= 1'b0;
            gpib_talk_only <= 1'b0;
        end else begin
            rts            <= sw_flow ? 1'b1 : ~rx_full_reg;
            dtr            <= 1'b1;
            gpib_talk_only <= ctrl_reg[`SPW_CTRL_REM_SER];
        end
    end
endmodule

// ---- rtl/spw_regs.vh ----
`ifndef SPW_REGS_VH
`define SPW_REGS_VH
`define SPW_ADDR_CTRL      4'h0
`define SPW_ADDR_BAUD      4'h1
`define SPW_ADDR_TXDATA    4'h2
`define SPW_ADDR_RXDATA    4'h3
`define SPW_ADDR_STATUS    4'h4
`define SPW_ADDR_GPIB      4'h5
`define SPW_CTRL_EIGHT     0
`define SPW_CTRL_PAR_EN    1
`define SPW_CTRL_PAR_ODD   2
`define SPW_CTRL_TWO_STOP  3
`define SPW_CTRL_SW_FLOW   4
`define SPW_CTRL_REM_SER   5
`define SPW_CTRL_RESET     8'h01
`define SPW_BAUD_RESET     16'h0410
`define SPW_GPIB_RESET     5'h01
`define SPW_XON            8'h11
`define SPW_XOFF           8'h13
`endif

// ---- rtl/spw_bit_timer.v ----
`timescale 1ns/10ps
module spw_bit_timer #(
    parameter WIDTH = 16
) (
    input  wire             core_clk,
    input  wire             reset,
    input  wire             restart,
    input  wire [WIDTH-1:0] divisor,
    output reg              tick
);
    reg [WIDTH-1:0] count_reg;
    always @(posedge core_clk) begin
        if (reset) begin
            count_reg <= {WIDTH{1'b0}};
            tick      <= 1'b0;
        end else if (restart) begin
            // The restart edge is already the first cycle of the new bit.
            count_reg <= {{(WIDTH-1){1'b0}}, 1'b1};
            tick      <= 1'b0;
        end else if (count_reg >= divisor) begin
            count_reg <= {WIDTH{1'b0}};
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            tick      <= 1'b0;
        end
    end
endmodule

// ---- tb/spw_serial_port_sva.sv ----
`timescale 1ns/10ps
`include "spw_regs.vh"
// ==========================================
// Port checker
module spw_serial_port_sva (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        rxd,
    input wire logic        cts,
    input wire logic        txd,
    input wire logic        rts,
    input wire logic        dtr,
    input wire logic        gpib_talk_only,
    input wire logic [4:0]  gpib_address
);
    logic       sw_reg;
    logic [6:0] idle_reg;
    // A long run of mark means the line is idle, not a run of ones inside a character.
    always @(posedge core_clk) begin
        if (reset) begin
            sw_reg   <= 1'b0;
            idle_reg <= 7'h00;
        end else begin
            if (reg_wr && reg_addr == `SPW_ADDR_CTRL) begin
                sw_reg <= reg_wdata[`SPW_CTRL_SW_FLOW];
            end
            idle_reg <= !txd ? 7'h00 : (idle_reg == 7'h7f ? idle_reg : idle_reg + 7'h01);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    reset_out_a: assert property (reset |=> !dtr && txd && !rts)
        else $error("outputs wrong after reset");
    reset_gpib_a: assert property (reset |=> gpib_address == `SPW_GPIB_RESET
        && !gpib_talk_only)
        else $error("bus outputs wrong after reset");
    dtr_on_a: assert property (disable iff (reset) !$past(reset) |-> dtr)
        else $error("dtr dropped");
    talk_only_a: assert property (disable iff (reset) reg_wr && reg_addr == `SPW_ADDR_CTRL
        |-> ##2 gpib_talk_only == $past(reg_wdata[`SPW_CTRL_REM_SER], 2))
        else $error("talk only not following setting");
    gpib_addr_a: assert property (disable iff (reset) reg_wr && reg_addr == `SPW_ADDR_GPIB
        |-> ##2 gpib_address == $past(reg_wdata[4:0], 2))
        else $error("bus address not updated");
    sw_rts_a: assert property (disable iff (reset) sw_reg && $past(sw_reg)
        && $past(sw_reg, 2) |-> rts)
        else $error("rts low under software flow");
    hw_rts_a: assert property (disable iff (reset)
        !sw_reg && reg_rd && reg_addr == `SPW_ADDR_RXDATA |-> ##[1:3] rts)
        else $error("rts not raised after receive read");
    cts_hold_a: assert property (disable iff (reset) idle_reg == 7'h7f && !cts && !$past(cts)
        && !$past(cts, 2) && !$past(cts, 3) |=> txd)
        else $error("character started without cts");
    cover property (disable iff (reset) !sw_reg && $fell(rts));
    cover property (disable iff (reset) idle_reg == 7'h7f && $fell(txd));
    cover property (disable iff (reset) $rose(gpib_talk_only));
endmodule

// ---- tb/spw_host_model.sv ----
`timescale 1ns/10ps
// ==========================================
// Far-side terminal
module spw_host_model (
    input  wire core_clk,
    input  wire txd,
    input  wire rts,
    output reg  rxd,
    output reg  cts
);
    initial begin
        rxd = 1'b1;
        cts = 1'b1;
    end
    // Bits leave LSB first, one period each; the line rests at mark afterwards.
    task send_frame(input logic [11:0] bits, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            rxd <= bits[i];
            repeat (per) @(posedge core_clk);
        end
        rxd <= 1'b1;
    endtask
    // Samples mid-bit; gives up after a bounded wait so a silent line cannot hang the run.
    task get_frame(input int n, input int per, output logic [11:0] bits);
        int t;
        bits = '1;
        t = 0;
        while (txd !== 1'b0 && t < 400) begin
            @(posedge core_clk);
            t++;
        end
        if (t < 400) begin
            repeat (per / 2) @(posedge core_clk);
            for (int i = 0; i < n; i++) begin
                bits[i] = txd;
                repeat (per) @(posedge core_clk);
            end
        end
    endtask
endmodule

// ---- tb/spw_serial_port_tb_top.sv ----
`timescale 1ns/10ps
`include "spw_regs.vh"
// ==========================================
// Bench top
module spw_serial_port_tb_top;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    wire  [15:0] reg_rdata;
    wire         rxd, cts, txd, rts, dtr, gpib_talk_only;
    wire  [4:0]  gpib_address;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [15:0] d;
    logic [11:0] f, g;
    int          n;
    spw_serial_port spw_serial_port_i (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd),
        .cts(cts), .txd(txd), .rts(rts), .dtr(dtr), .gpib_talk_only(gpib_talk_only),
        .gpib_address(gpib_address));
    spw_host_model spw_host_model_i (.core_clk(core_clk), .txd(txd), .rts(rts),
        .rxd(rxd), .cts(cts));
    always #50 core_clk = ~core_clk;
    // ==========================================
    // Shared tasks
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Expected line pattern: start, data LSB first, parity, stop bits.
    function automatic int mk(input logic [7:0] v, input logic [5:0] c, output logic [11:0] fr);
        int k;
        logic [7:0] m;
        m = c[0] ? v : {1'b0, v[6:0]};
        fr = '1;
        fr[0] = 1'b0;
        k = 1;
        for (int i = 0; i < (c[0] ? 8 : 7); i++) begin
            fr[k] = m[i];
            k++;
        end
        if (c[1]) begin
            fr[k] = (^m) ^ c[2];
            k++;
        end
        return k + (c[3] ? 2 : 1);
    endfunction
    task tx_chk(input logic [7:0] v, input logic [5:0] c);
        wr(`SPW_ADDR_TXDATA, {8'h00, v});
        n = mk(v, c, f);
        spw_host_model_i.get_frame(n, 8, g);
        chk("frame", {4'h0, g}, {4'h0, f});
    endtask
    // ==========================================
    // Scenarios
    task t_reset();
        rd(`SPW_ADDR_CTRL);
        chk("ctrl", d, {8'h00, `SPW_CTRL_RESET});
        rd(`SPW_ADDR_BAUD);
        chk("baud", d, `SPW_BAUD_RESET);
        rd(`SPW_ADDR_GPIB);
        chk("gpib", d, {11'h000, `SPW_GPIB_RESET});
        rd(4'h7);
        chk("unmapped", d, 16'h0000);
        chk("dtr", {15'h0, dtr}, 16'h0001);
        chk("rts", {15'h0, rts}, 16'h0001);
    endtask
    task t_modes();
        logic [5:0] cfg [6];
        cfg = '{6'h01, 6'h02, 6'h0f, 6'h08, 6'h03, 6'h06};
        wr(`SPW_ADDR_BAUD, 16'h0007);
        for (int i = 0; i < 6; i++) begin
            wr(`SPW_ADDR_CTRL, {10'h0, cfg[i]});
            tx_chk(8'ha5 ^ 8'(i * 8'h13), cfg[i]);
        end
    endtask
    task t_cts();
        spw_host_model_i.cts <= 1'b0;
        wr(`SPW_ADDR_CTRL, 16'h0001);
        wr(`SPW_ADDR_TXDATA, 16'h005a);
        n = 0;
        repeat (150) begin
            @(posedge core_clk);
            n += (txd !== 1'b1);
        end
        chk("held", 16'(n), 16'h0000);
        rd(`SPW_ADDR_STATUS);
        chk("tx full", {15'h0, d[0]}, 16'h0001);
        spw_host_model_i.cts <= 1'b1;
        n = mk(8'h5a, 6'h01, f);
        spw_host_model_i.get_frame(n, 8, g);
        chk("late frame", {4'h0, g}, {4'h0, f});
    endtask
    task t_rx();
        spw_host_model_i.send_frame({3'b111, 8'h3c, 1'b0}, 10, 8);
        repeat (3) @(posedge core_clk);
        chk("rts full", {15'h0, rts}, 16'h0000);
        rd(`SPW_ADDR_RXDATA);
        chk("rx data", {8'h00, d[7:0]}, 16'h003c);
        repeat (3) @(posedge core_clk);
        chk("rts free", {15'h0, rts}, 16'h0001);
        wr(`SPW_ADDR_CTRL, 16'h0003);
        spw_host_model_i.send_frame({3'b111, 8'h3c, 1'b0}, 11, 8);
        rd(`SPW_ADDR_STATUS);
        chk("parity err", {15'h0, d[2]}, 16'h0001);
        rd(`SPW_ADDR_RXDATA);
    endtask
    task t_sw();
        wr(`SPW_ADDR_CTRL, 16'h0011);
        spw_host_model_i.send_frame({3'b111, 8'h3c, 1'b0}, 10, 8);
        repeat (3) @(posedge core_clk);
        chk("rts sw", {15'h0, rts}, 16'h0001);
        rd(`SPW_ADDR_RXDATA);
        spw_host_model_i.send_frame({3'b111, `SPW_XOFF, 1'b0}, 10, 8);
        wr(`SPW_ADDR_TXDATA, 16'h0077);
        repeat (100) @(posedge core_clk);
        rd(`SPW_ADDR_STATUS);
        chk("xoff", {13'h0, d[6], d[1], d[0]}, 16'h0005);
        n = mk(8'h77, 6'h01, f);
        fork
            spw_host_model_i.send_frame({3'b111, `SPW_XON, 1'b0}, 10, 8);
            spw_host_model_i.get_frame(n, 8, g);
        join
        chk("xon frame", {4'h0, g}, {4'h0, f});
    endtask
    task t_talk();
        wr(`SPW_ADDR_CTRL, 16'h0021);
        repeat (3) @(posedge core_clk);
        chk("talk", {15'h0, gpib_talk_only}, 16'h0001);
        wr(`SPW_ADDR_GPIB, 16'h000a);
        repeat (3) @(posedge core_clk);
        chk("addr", {11'h0, gpib_address}, 16'h000a);
        wr(`SPW_ADDR_CTRL, 16'h0001);
        repeat (3) @(posedge core_clk);
        chk("no talk", {15'h0, gpib_talk_only}, 16'h0000);
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_modes();
        t_cts();
        t_rx();
        t_sw();
        t_talk();
        report_and_stop();
    end
endmodule
bind spw_serial_port spw_serial_port_sva spw_chk_i (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rxd(rxd), .cts(cts), .txd(txd), .rts(rts), .dtr(dtr),
    .gpib_talk_only(gpib_talk_only), .gpib_address(gpib_address));
